// ==== common/bic_pkg.sv ====
// constants for the bridge address, reset and lane-mapping register bank
package bic_pkg;
  localparam logic [7:0] OWN_ADDR_OFS = 8'h00;
  localparam logic [7:0] RST_CTL_OFS = 8'h01;
  localparam logic [7:0] LANE_MAP_OFS = 8'h02;
  localparam int SRC_SEL_BIT = 0;
  localparam int ADDR_LSB = 1;
  localparam int ADDR_MSB = 7;
  localparam int RST_HOLD_BIT = 3;
  localparam int RST_PULSE_BIT = 2;
  localparam int RST_ALL_BIT = 1;
  localparam int RST_KEEP_BIT = 0;
  localparam int P0_REV_BIT = 0;
  localparam int P0_DATA_SWAP_BIT = 1;
  localparam int P0_CLK_SWAP_BIT = 2;
  localparam int P1_REV_BIT = 4;
  localparam int P1_DATA_SWAP_BIT = 5;
  localparam int P1_CLK_SWAP_BIT = 6;
  localparam logic [7:0] LANE_MAP_MASK = 8'h77;
  localparam logic [7:0] LANE_MAP_RESET = 8'h00;
  localparam logic [6:0] ADDR_FIELD_RESET = 7'h00;
  localparam logic [6:0] ADDR_ONE = 7'h01;
  localparam logic SRC_SEL_RESET = 1'b0;
  localparam logic HOLD_RESET = 1'b0;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam int CLK_MHZ = 40;
  localparam int PULSE_NS = 100;
  localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int PULSE_CW = 4;
  localparam logic [PULSE_CW-1:0] PULSE_LOAD = PULSE_CW'(PULSE_CYC);
  localparam logic [PULSE_CW-1:0] PULSE_ONE = 4'h1;
  localparam logic [PULSE_CW-1:0] PULSE_IDLE = 4'h0;
  localparam int LANES = 4;
endpackage

// ==== core/bic_regs.sv ====
// address, reset-control and input lane-mapping register bank of the bridge
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// (RL1) The own 7-bit bus address sits in bits 7:1 of register 0x00 and starts at the strap value.
// (RL2) With the second-port enable set, the second port's address is the answering address plus one.
// (RL3) The host writes the address field with its lowest bit zero so the second port derives cleanly.
// (RL4) Bit 0 of register 0x00 picks the answering address: 0 the strap, 1 the programmed field.
// (RL5) Reset bit 3 holds the video input logic in reset while 1, never self-clears, starts from strap.
// (RL6) Writing 1 to reset bit 2 gives the video input logic a short reset pulse and the bit returns to 0.
// (RL7) Writing 1 to reset bit 1 resets the whole core including all configuration, then self-clears.
// (RL8) Writing 1 to reset bit 0 resets the core but keeps configuration, then self-clears.
// (RL9) The keep-registers core reset still reloads every strap-loaded field from its strap.
// (RL10) Register 0x02 bits 6 and 2 swap the clock lane P and N inputs of ports 1 and 0.
// (RL11) Register 0x02 bits 5 and 1 swap P and N on all data lanes of ports 1 and 0.
// (RL12) Register 0x02 bits 4 and 0 reverse the data lane order of ports 1 and 0.
// (RL13) Strap-loaded fields take the strap at startup and stay writable afterwards.
// (RL14) The bank is reachable from both the local bus port and the remote control channel.
// (RL15) Reserved bits read zero and writes to them are ignored.
// (RL16) Self-clearing reset bits read zero so the host can write 1 again.
module bic_regs (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [6:0] address_strap_pin,
  input wire logic mode_strap_pin_one,
  input wire logic second_port_bus_enable,
  input wire logic [7:0] loc_addr,
  input wire logic [7:0] loc_wdata,
  input wire logic loc_wr,
  input wire logic loc_rd,
  output logic [7:0] loc_rdata,
  output logic loc_rvalid,
  input wire logic [7:0] rem_addr,
  input wire logic [7:0] rem_wdata,
  input wire logic rem_wr,
  input wire logic rem_rd,
  output logic [7:0] rem_rdata,
  output logic rem_rvalid,
  input wire logic [3:0] port0_data_p,
  input wire logic [3:0] port0_data_n,
  input wire logic port0_clk_p,
  input wire logic port0_clk_n,
  input wire logic [3:0] port1_data_p,
  input wire logic [3:0] port1_data_n,
  input wire logic port1_clk_p,
  input wire logic port1_clk_n,
  output logic [3:0] port0_lane_p,
  output logic [3:0] port0_lane_n,
  output logic port0_lclk_p,
  output logic port0_lclk_n,
  output logic [3:0] port1_lane_p,
  output logic [3:0] port1_lane_n,
  output logic port1_lclk_p,
  output logic port1_lclk_n,
  output logic [6:0] active_address,
  output logic [6:0] second_port_address,
  output logic second_port_active,
  output logic video_input_reset,
  output logic core_reset_with_registers,
  output logic core_reset_keep_registers
);

  function automatic logic [3:0] map_lanes(input logic [3:0] v, input logic rev);
    map_lanes = rev ? {v[0], v[1], v[2], v[3]} : v;
  endfunction

  function automatic logic [6:0] addr_plus_one(input logic [6:0] a);
    addr_plus_one = a + bic_pkg::ADDR_ONE;
  endfunction

  logic strap_done_r;
  logic [6:0] strap_addr_r;
  logic [6:0] addr_field_r;
  logic src_sel_r;
  logic hold_r;
  logic [7:0] lane_r;
  logic [bic_pkg::PULSE_CW-1:0] pulse_cnt_r;
  logic [6:0] active_address_r;
  logic [6:0] second_port_address_r;
  logic second_port_active_r;
  logic video_input_reset_r;
  logic core_all_r;
  logic core_keep_r;
  logic [7:0] loc_rdata_r;
  logic loc_rvalid_r;
  logic [7:0] rem_rdata_r;
  logic rem_rvalid_r;
  logic [3:0] p0_p_r;
  logic [3:0] p0_n_r;
  logic p0_cp_r;
  logic p0_cn_r;
  logic [3:0] p1_p_r;
  logic [3:0] p1_n_r;
  logic p1_cp_r;
  logic p1_cn_r;

  // both access paths write the same bank; the local port wins a same-cycle clash
  wire logic loc_addr_we = loc_wr && (loc_addr == bic_pkg::OWN_ADDR_OFS); // RL14
  wire logic rem_addr_we = rem_wr && (rem_addr == bic_pkg::OWN_ADDR_OFS); // RL14
  wire logic loc_rst_we = loc_wr && (loc_addr == bic_pkg::RST_CTL_OFS);
  wire logic rem_rst_we = rem_wr && (rem_addr == bic_pkg::RST_CTL_OFS);
  wire logic loc_lane_we = loc_wr && (loc_addr == bic_pkg::LANE_MAP_OFS);
  wire logic rem_lane_we = rem_wr && (rem_addr == bic_pkg::LANE_MAP_OFS);
  wire logic addr_we = loc_addr_we || rem_addr_we;
  wire logic rst_we = loc_rst_we || rem_rst_we;
  wire logic lane_we = loc_lane_we || rem_lane_we;
  wire logic [7:0] addr_wd = loc_addr_we ? loc_wdata : rem_wdata;
  wire logic [7:0] rst_wd = loc_rst_we ? loc_wdata : rem_wdata;
  wire logic [7:0] lane_wd = loc_lane_we ? loc_wdata : rem_wdata;

  wire logic all_trig = rst_we && rst_wd[bic_pkg::RST_ALL_BIT]; // RL7
  wire logic keep_trig = rst_we && rst_wd[bic_pkg::RST_KEEP_BIT]; // RL8
  wire logic pulse_trig = rst_we && rst_wd[bic_pkg::RST_PULSE_BIT]; // RL6
  // straps are caught on the first edge after release and again on either core reset
  wire logic strap_load = !strap_done_r || keep_trig || all_trig; // RL9 RL13

  wire logic [6:0] strap_addr_nxt = strap_load ? address_strap_pin : strap_addr_r;
  wire logic [6:0] addr_field_nxt = strap_load ? address_strap_pin :
      addr_we ? addr_wd[bic_pkg::ADDR_MSB:bic_pkg::ADDR_LSB] : addr_field_r; // RL1 RL13
  wire logic src_sel_nxt = all_trig ? bic_pkg::SRC_SEL_RESET :
      addr_we ? addr_wd[bic_pkg::SRC_SEL_BIT] : src_sel_r;
  wire logic hold_nxt = strap_load ? mode_strap_pin_one :
      rst_we ? rst_wd[bic_pkg::RST_HOLD_BIT] : hold_r; // RL5
  // reserved lane-map bits never reach the register
  wire logic [7:0] lane_nxt = all_trig ? bic_pkg::LANE_MAP_RESET :
      lane_we ? (lane_wd & bic_pkg::LANE_MAP_MASK) : lane_r; // RL15
  wire logic [bic_pkg::PULSE_CW-1:0] pulse_cnt_nxt = pulse_trig ? bic_pkg::PULSE_LOAD :
      (pulse_cnt_r != bic_pkg::PULSE_IDLE) ? pulse_cnt_r - bic_pkg::PULSE_ONE : pulse_cnt_r;
  wire logic [6:0] answer_addr_nxt = src_sel_nxt ? addr_field_nxt : strap_addr_nxt; // RL4
  // the clear-on-write reset bits are not stored, so they always read zero
  wire logic [7:0] rst_view = {4'h0, hold_r, 3'h0}; // RL16 RL15
  wire logic [7:0] addr_view = {addr_field_r, src_sel_r};

  function automatic logic [7:0] read_mux(input logic [7:0] a, input logic [7:0] av,
                                          input logic [7:0] rv, input logic [7:0] lv);
    if (a == bic_pkg::OWN_ADDR_OFS) begin
      read_mux = av;
    end else if (a == bic_pkg::RST_CTL_OFS) begin
      read_mux = rv;
    end else if (a == bic_pkg::LANE_MAP_OFS) begin
      read_mux = lv;
    end else begin
      read_mux = bic_pkg::READ_ZERO;
    end
  endfunction

  wire logic [7:0] loc_rd_nxt = read_mux(loc_addr, addr_view, rst_view, lane_r);
  wire logic [7:0] rem_rd_nxt = read_mux(rem_addr, addr_view, rst_view, lane_r);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      strap_done_r <= 1'b0;
      strap_addr_r <= bic_pkg::ADDR_FIELD_RESET;
      addr_field_r <= bic_pkg::ADDR_FIELD_RESET;
      src_sel_r <= bic_pkg::SRC_SEL_RESET;
      hold_r <= bic_pkg::HOLD_RESET;
      lane_r <= bic_pkg::LANE_MAP_RESET;
      pulse_cnt_r <= bic_pkg::PULSE_IDLE;
    end else begin
      strap_done_r <= 1'b1;
      strap_addr_r <= strap_addr_nxt;
      addr_field_r <= addr_field_nxt;
      src_sel_r <= src_sel_nxt;
      hold_r <= hold_nxt;
      lane_r <= lane_nxt;
      pulse_cnt_r <= pulse_cnt_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      active_address_r <= bic_pkg::ADDR_FIELD_RESET;
      second_port_address_r <= bic_pkg::ADDR_FIELD_RESET;
      second_port_active_r <= 1'b0;
      video_input_reset_r <= 1'b0;
      core_all_r <= 1'b0;
      core_keep_r <= 1'b0;
    end else begin
      active_address_r <= answer_addr_nxt; // RL4
      second_port_address_r <= addr_plus_one(answer_addr_nxt); // RL2
      second_port_active_r <= second_port_bus_enable;
      video_input_reset_r <= hold_nxt || (pulse_cnt_nxt != bic_pkg::PULSE_IDLE); // RL5 RL6
      core_all_r <= all_trig; // RL7
      core_keep_r <= keep_trig; // RL8
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      loc_rdata_r <= bic_pkg::READ_ZERO;
      loc_rvalid_r <= 1'b0;
      rem_rdata_r <= bic_pkg::READ_ZERO;
      rem_rvalid_r <= 1'b0;
    end else begin
      loc_rdata_r <= loc_rd ? loc_rd_nxt : loc_rdata_r;
      loc_rvalid_r <= loc_rd;
      rem_rdata_r <= rem_rd ? rem_rd_nxt : rem_rdata_r; // RL14
      rem_rvalid_r <= rem_rd;
    end
  end

  // lane remap costs one register stage of latency on every input
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      p0_p_r <= 4'h0;
      p0_n_r <= 4'h0;
      p0_cp_r <= 1'b0;
      p0_cn_r <= 1'b0;
      p1_p_r <= 4'h0;
      p1_n_r <= 4'h0;
      p1_cp_r <= 1'b0;
      p1_cn_r <= 1'b0;
    end else begin
      p0_p_r <= map_lanes(lane_r[bic_pkg::P0_DATA_SWAP_BIT] ? port0_data_n : port0_data_p,
                          lane_r[bic_pkg::P0_REV_BIT]); // RL11 RL12
      p0_n_r <= map_lanes(lane_r[bic_pkg::P0_DATA_SWAP_BIT] ? port0_data_p : port0_data_n,
                          lane_r[bic_pkg::P0_REV_BIT]); // RL11 RL12
      p0_cp_r <= lane_r[bic_pkg::P0_CLK_SWAP_BIT] ? port0_clk_n : port0_clk_p; // RL10
      p0_cn_r <= lane_r[bic_pkg::P0_CLK_SWAP_BIT] ? port0_clk_p : port0_clk_n; // RL10
      p1_p_r <= map_lanes(lane_r[bic_pkg::P1_DATA_SWAP_BIT] ? port1_data_n : port1_data_p,
                          lane_r[bic_pkg::P1_REV_BIT]); // RL11 RL12
      p1_n_r <= map_lanes(lane_r[bic_pkg::P1_DATA_SWAP_BIT] ? port1_data_p : port1_data_n,
                          lane_r[bic_pkg::P1_REV_BIT]); // RL11 RL12
      p1_cp_r <= lane_r[bic_pkg::P1_CLK_SWAP_BIT] ? port1_clk_n : port1_clk_p; // RL10
      p1_cn_r <= lane_r[bic_pkg::P1_CLK_SWAP_BIT] ? port1_clk_p : port1_clk_n; // RL10
    end
  end

  assign loc_rdata = loc_rdata_r;
  assign loc_rvalid = loc_rvalid_r;
  assign rem_rdata = rem_rdata_r;
  assign rem_rvalid = rem_rvalid_r;
  assign port0_lane_p = p0_p_r;
  assign port0_lane_n = p0_n_r;
  assign port0_lclk_p = p0_cp_r;
  assign port0_lclk_n = p0_cn_r;
  assign port1_lane_p = p1_p_r;
  assign port1_lane_n = p1_n_r;
  assign port1_lclk_p = p1_cp_r;
  assign port1_lclk_n = p1_cn_r;
  assign active_address = active_address_r;
  assign second_port_address = second_port_address_r;
  assign second_port_active = second_port_active_r;
  assign video_input_reset = video_input_reset_r;
  assign core_reset_with_registers = core_all_r;
  assign core_reset_keep_registers = core_keep_r;

  property p_strap_start;
    @(posedge ref_clk) disable iff (!rstn)
    !strap_done_r |=> addr_field_r == $past(address_strap_pin);
  endproperty
  a_strap_start: assert property (p_strap_start) else $error("address field missed strap"); // RL1

  property p_answer_src;
    @(posedge ref_clk) disable iff (!rstn)
    strap_done_r |-> active_address_r == (src_sel_r ? addr_field_r : strap_addr_r);
  endproperty
  a_answer_src: assert property (p_answer_src) else $error("wrong answering address"); // RL4

  property p_second_addr;
    @(posedge ref_clk) disable iff (!rstn)
    strap_done_r |-> second_port_address_r == addr_plus_one(active_address_r);
  endproperty
  a_second_addr: assert property (p_second_addr) else $error("second address not plus one"); // RL2

  property p_hold_level;
    @(posedge ref_clk) disable iff (!rstn)
    strap_done_r && hold_r |-> video_input_reset_r;
  endproperty
  a_hold_level: assert property (p_hold_level) else $error("held video reset not applied"); // RL5

  property p_video_pulse;
    @(posedge ref_clk) disable iff (!rstn)
    pulse_trig && !all_trig && !keep_trig |=> video_input_reset_r [*4];
  endproperty
  a_video_pulse: assert property (p_video_pulse) else $error("video reset pulse too short"); // RL6

  property p_core_all;
    @(posedge ref_clk) disable iff (!rstn)
    all_trig |=> core_all_r && lane_r == bic_pkg::LANE_MAP_RESET && !src_sel_r;
  endproperty
  a_core_all: assert property (p_core_all) else $error("full core reset kept config"); // RL7

  property p_core_keep;
    @(posedge ref_clk) disable iff (!rstn)
    keep_trig && !all_trig && !lane_we |=> core_keep_r && lane_r == $past(lane_r);
  endproperty
  a_core_keep: assert property (p_core_keep) else $error("keep reset lost config"); // RL8

  property p_strap_reload;
    @(posedge ref_clk) disable iff (!rstn)
    keep_trig |=> addr_field_r == $past(address_strap_pin) && hold_r == $past(mode_strap_pin_one);
  endproperty
  a_strap_reload: assert property (p_strap_reload) else $error("strap fields not reloaded"); // RL9

  property p_rst_read;
    @(posedge ref_clk) disable iff (!rstn)
    loc_rd && loc_addr == bic_pkg::RST_CTL_OFS |=> loc_rvalid_r && loc_rdata_r[2:0] == 3'h0
      && loc_rdata_r[7:4] == 4'h0 && loc_rdata_r[bic_pkg::RST_HOLD_BIT] == $past(hold_r);
  endproperty
  a_rst_read: assert property (p_rst_read) else $error("reset register read wrong"); // RL16

  property p_remote_write;
    @(posedge ref_clk) disable iff (!rstn)
    rem_lane_we && !loc_lane_we && !all_trig |=> lane_r == ($past(rem_wdata) & bic_pkg::LANE_MAP_MASK);
  endproperty
  a_remote_write: assert property (p_remote_write) else $error("remote write not stored"); // RL14

  property p_port0_map;
    @(posedge ref_clk) disable iff (!rstn)
    lane_r[bic_pkg::P0_REV_BIT] && !lane_r[bic_pkg::P0_DATA_SWAP_BIT] && !lane_we
      |=> port0_lane_p == {$past(port0_data_p[0]), $past(port0_data_p[1]),
                           $past(port0_data_p[2]), $past(port0_data_p[3])};
  endproperty
  a_port0_map: assert property (p_port0_map) else $error("port0 lane order wrong"); // RL12

  property p_port1_clk;
    @(posedge ref_clk) disable iff (!rstn)
    lane_r[bic_pkg::P1_CLK_SWAP_BIT] |=> port1_lclk_p == $past(port1_clk_n);
  endproperty
  a_port1_clk: assert property (p_port1_clk) else $error("port1 clock swap wrong"); // RL10

endmodule
`default_nettype wire

// ==== testbench/bic_host_model.sv ====
// register bus host model, one instance per access path (local port, remote channel)
`timescale 1ns/100ps
`default_nettype none
module bic_host_model (
  input wire logic ref_clk,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  // an idle edge comes first, so back-to-back calls never retoggle a strobe in one time step;
  // left just after the one edge that takes the request
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge ref_clk);
    #1;
    wr = 1'b0;
    // released lines show the inverse so a stale value is never trusted
    addr = ~a;
    wdata = ~d;
  endtask
  task automatic get(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge ref_clk);
    #1;
    addr = a;
    rd = 1'b1;
    @(posedge ref_clk);
    #1;
    rd = 1'b0;
    addr = ~a;
    for (int k = 0; k < 4 && rvalid !== 1'b1; k++) begin
      @(posedge ref_clk);
      #1;
    end
    ok = (rvalid === 1'b1);
    d = rdata;
  endtask
endmodule
`default_nettype wire

// ==== testbench/bridge_id_reset_lane_cfg_regs_tb_top.sv ====
// self-checking bench for the address, reset and lane-mapping register bank
`timescale 1ns/100ps
`default_nettype none
module bridge_id_reset_lane_cfg_regs_tb_top;
  localparam logic [6:0] STRAP = 7'h2c;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [6:0] strap_addr = STRAP;
  logic mode_strap = 1'b1;
  logic p1_en = 1'b1;
  logic [7:0] la, lw, lr, ra, rw, rr;
  logic lwr, lrd, lv, rwr, rrd, rv;
  logic [3:0] d0p = 4'h1, d0n = 4'h6, d1p = 4'h2, d1n = 4'hd;
  logic c0p = 1'b1, c0n = 1'b0, c1p = 1'b0, c1n = 1'b1;
  logic [3:0] o0p, o0n, o1p, o1n;
  logic k0p, k0n, k1p, k1n, vrst, crst_all, crst_keep, sp_act;
  logic [6:0] act_addr, sp_addr;
  int n_mismatch = 0;
  int comparisons = 0;
  always #12.5 ref_clk = ~ref_clk;
  bic_regs DUT (.ref_clk(ref_clk), .rstn(rstn), .address_strap_pin(strap_addr),
    .mode_strap_pin_one(mode_strap), .second_port_bus_enable(p1_en),
    .loc_addr(la), .loc_wdata(lw), .loc_wr(lwr), .loc_rd(lrd), .loc_rdata(lr), .loc_rvalid(lv),
    .rem_addr(ra), .rem_wdata(rw), .rem_wr(rwr), .rem_rd(rrd), .rem_rdata(rr), .rem_rvalid(rv),
    .port0_data_p(d0p), .port0_data_n(d0n), .port0_clk_p(c0p), .port0_clk_n(c0n),
    .port1_data_p(d1p), .port1_data_n(d1n), .port1_clk_p(c1p), .port1_clk_n(c1n),
    .port0_lane_p(o0p), .port0_lane_n(o0n), .port0_lclk_p(k0p), .port0_lclk_n(k0n),
    .port1_lane_p(o1p), .port1_lane_n(o1n), .port1_lclk_p(k1p), .port1_lclk_n(k1n),
    .active_address(act_addr), .second_port_address(sp_addr), .second_port_active(sp_act),
    .video_input_reset(vrst), .core_reset_with_registers(crst_all),
    .core_reset_keep_registers(crst_keep));
  bic_host_model loc_h (.ref_clk(ref_clk), .addr(la), .wdata(lw), .wr(lwr), .rd(lrd),
    .rdata(lr), .rvalid(lv));
  bic_host_model rem_h (.ref_clk(ref_clk), .addr(ra), .wdata(rw), .wr(rwr), .rd(rrd),
    .rdata(rr), .rvalid(rv));
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rdc(input bit rem, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    if (rem) rem_h.get(a, d, ok);
    else loc_h.get(a, d, ok);
    if (!ok) begin
      n_mismatch++;
      $display("[ERR] read valid expected 1 seen 0");
      test_done();
    end else begin
      chk($sformatf("reg %h", a), {8'h00, exp}, {8'h00, d});
    end
  endtask
  function automatic logic [15:0] lmap(input logic [2:0] m, input logic [3:0] p,
                                       input logic [3:0] n, input logic cp, input logic cn);
    logic [3:0] a, b;
    a = m[1] ? n : p;
    b = m[1] ? p : n;
    if (m[0]) begin
      a = {a[0], a[1], a[2], a[3]};
      b = {b[0], b[1], b[2], b[3]};
    end
    return {6'h0, a, b, m[2] ? cn : cp, m[2] ? cp : cn};
  endfunction
  task automatic t_straps();
    rdc(0, bic_pkg::OWN_ADDR_OFS, {STRAP, 1'b0});
    rdc(1, bic_pkg::RST_CTL_OFS, 8'h08);
    rdc(0, bic_pkg::LANE_MAP_OFS, 8'h00);
    rdc(0, 8'h05, 8'h00);
    chk("active_address", {9'h0, STRAP}, {9'h0, act_addr});
    chk("second_port_address", {9'h0, STRAP + 7'h01}, {9'h0, sp_addr});
    chk("second_port_active", 16'h0001, {15'h0, sp_act});
    chk("video_input_reset", 16'h0001, {15'h0, vrst});
    $display("test straps done");
  endtask
  task automatic t_addr();
    // programmed address keeps its lowest bit zero so the second port derives cleanly
    loc_h.put(bic_pkg::OWN_ADDR_OFS, {7'h3a, 1'b1});
    rem_h.put(8'h05, 8'hff);
    rdc(1, bic_pkg::OWN_ADDR_OFS, {7'h3a, 1'b1});
    rdc(0, 8'h05, 8'h00);
    chk("active_address", 16'h003a, {9'h0, act_addr});
    chk("second_port_address", 16'h003b, {9'h0, sp_addr});
    p1_en = 1'b0;
    loc_h.put(bic_pkg::OWN_ADDR_OFS, {7'h3a, 1'b0});
    @(posedge ref_clk);
    #1;
    chk("active_address", {9'h0, STRAP}, {9'h0, act_addr});
    chk("second_port_active", 16'h0000, {15'h0, sp_act});
    p1_en = 1'b1;
    $display("test address done");
  endtask
  task automatic t_lane();
    logic [7:0] m;
    for (int i = 0; i < 8; i++) begin
      m = {1'b0, i[2:0], 1'b0, i[2:0] ^ 3'h5};
      if (i[0]) rem_h.put(bic_pkg::LANE_MAP_OFS, m | 8'h88);
      else loc_h.put(bic_pkg::LANE_MAP_OFS, m);
      repeat (2) begin
        @(posedge ref_clk);
        #1;
      end
      chk("port0 lanes", lmap(m[2:0], d0p, d0n, c0p, c0n), {6'h0, o0p, o0n, k0p, k0n});
      chk("port1 lanes", lmap(m[6:4], d1p, d1n, c1p, c1n), {6'h0, o1p, o1n, k1p, k1n});
      rdc(0, bic_pkg::LANE_MAP_OFS, m);
    end
    $display("test lanes done");
  endtask
  task automatic t_resets();
    loc_h.put(bic_pkg::RST_CTL_OFS, 8'hf0);
    rdc(0, bic_pkg::RST_CTL_OFS, 8'h00);
    chk("video_input_reset", 16'h0000, {15'h0, vrst});
    loc_h.put(bic_pkg::RST_CTL_OFS, 8'h04);
    for (int k = 0; k < bic_pkg::PULSE_CYC; k++) begin
      chk("video pulse", 16'h0001, {15'h0, vrst});
      @(posedge ref_clk);
      #1;
    end
    chk("video pulse end", 16'h0000, {15'h0, vrst});
    rdc(1, bic_pkg::RST_CTL_OFS, 8'h00);
    loc_h.put(bic_pkg::LANE_MAP_OFS, 8'h55);
    loc_h.put(bic_pkg::OWN_ADDR_OFS, 8'h75);
    loc_h.put(bic_pkg::RST_CTL_OFS, 8'h01);
    chk("keep pulse", 16'h0001, {15'h0, crst_keep});
    chk("full pulse", 16'h0000, {15'h0, crst_all});
    rdc(0, bic_pkg::RST_CTL_OFS, 8'h08);
    chk("keep pulse end", 16'h0000, {15'h0, crst_keep});
    rdc(0, bic_pkg::LANE_MAP_OFS, 8'h55);
    rdc(0, bic_pkg::OWN_ADDR_OFS, {STRAP, 1'b1});
    loc_h.put(bic_pkg::RST_CTL_OFS, 8'h02);
    chk("full pulse", 16'h0001, {15'h0, crst_all});
    rdc(0, bic_pkg::LANE_MAP_OFS, 8'h00);
    rdc(0, bic_pkg::OWN_ADDR_OFS, {STRAP, 1'b0});
    rdc(0, bic_pkg::RST_CTL_OFS, 8'h08);
    chk("video_input_reset", 16'h0001, {15'h0, vrst});
    $display("test resets done");
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    // first edge loads the straps and already shows them on the outputs; the second is spare
    repeat (2) @(posedge ref_clk);
    #1;
    t_straps();
    t_addr();
    t_lane();
    t_resets();
    test_done();
  end
endmodule
`default_nettype wire
